/* rtl/fsr_framer.sv */
// Purpose: answers the full-status query of a stepper positioning node with two slave responses
// Assumes: link layer strobes each header identifier and each received byte; tx bytes leave in order
// Notes: all status is snapshotted when the first reply starts, so both replies tell one story
`default_nettype none

module fsr_framer #(
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // link layer receive side
  input wire logic i_hdr_valid,
  input wire logic [7:0] i_hdr_pid,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  // link layer transmit side
  output logic o_tx_valid,
  output logic [7:0] o_tx_byte,
  input wire logic i_tx_ready,
  // node identity and motion configuration
  input wire logic [6:0] i_node_address,
  input wire logic [3:0] i_run_current,
  input wire logic [3:0] i_hold_current,
  input wire logic [3:0] i_top_speed,
  input wire logic [3:0] i_start_speed,
  input wire logic i_accel_profile_shape,
  input wire logic [1:0] i_microstep_resolution,
  input wire logic i_direction,
  input wire logic [3:0] i_acceleration,
  // fault and warning flags
  input wire logic i_logic_supply_reset_flag,
  input wire logic i_lost_steps_flag,
  input wire logic i_coil_fault,
  input wire logic i_undervoltage_flag,
  input wire logic i_thermal_shutdown,
  input wire logic i_thermal_warning,
  input wire logic [1:0] i_temperature_info,
  input wire logic [2:0] i_motion_state,
  input wire logic i_external_switch,
  input wire logic i_coil_x_overcurrent,
  input wire logic i_coil_y_overcurrent,
  input wire logic i_stall_flag,
  input wire logic i_charge_pump_fault,
  input wire logic i_timeout_error,
  input wire logic i_frame_data_error,
  input wire logic i_header_error,
  input wire logic i_bit_error,
  // positions
  input wire logic [15:0] i_actual_position,
  input wire logic [15:0] i_target_position,
  input wire logic [10:0] i_secure_position,
  // stall detection
  input wire logic [3:0] i_absolute_threshold,
  input wire logic [3:0] i_delta_threshold,
  input wire logic [2:0] i_fullstep_stall_enable,
  input wire logic i_full_duty_indicator,
  input wire logic i_absolute_stall_flag,
  input wire logic i_delta_stall_low,
  input wire logic i_delta_stall_high,
  input wire logic [2:0] i_min_sample_count,
  input wire logic i_full_duty_stall_enable,
  input wire logic i_pwm_jitter_enable,
  // status toward the node
  output logic o_reply_pending,
  output logic o_second_pending,
  output logic o_busy,
  output logic o_flag_clear,
  output logic o_frame_error
);
  import fsr_pkg::*;

  fsr_state_e state_reg;
  logic [3:0] idx_reg;
  logic [7:0] sum_reg;
  logic match_reg;
  logic pend_first_reg;
  logic pend_second_reg;
  logic sending_first_reg;
  logic [63:0] snap_first_reg;
  logic [63:0] snap_second_reg;
  logic flag_clear_reg;
  logic frame_error_reg;

  logic [63:0] word_first;
  logic [63:0] word_second;
  logic [63:0] tx_word;
  logic [7:0] tx_data;
  logic [7:0] prep_expect;
  logic buf_in_ready;
  logic push;
  logic hdr_parity_ok;
  logic last_push;
  logic prep_done;
  logic prep_good;
  logic hdr_prep;
  logic hdr_read;
  logic rx_data;

  // picks data byte i of a 64-bit reply word, byte 0 in the top bits
  function automatic logic [7:0] byte_of(input logic [63:0] w, input logic [3:0] i);
    logic [5:0] sh;
    sh = {~i[2:0], 3'b000};
    return w[sh +: 8];
  endfunction

  // a header counts only when its parity is right for the id that it names
  function automatic logic hdr_is(input logic [7:0] pid, input logic [5:0] id);
    return pid == fsr_pid(id);
  endfunction

  // first reply contents
  assign word_first = {
    FSR_MARK_BIT, i_node_address,
    i_run_current, i_hold_current,
    i_top_speed, i_start_speed,
    i_accel_profile_shape, i_microstep_resolution, i_direction, i_acceleration,
    i_logic_supply_reset_flag, i_lost_steps_flag, i_coil_fault,
    i_undervoltage_flag, i_thermal_shutdown, i_thermal_warning, i_temperature_info,
    i_motion_state, i_external_switch, i_coil_x_overcurrent,
    i_coil_y_overcurrent, i_stall_flag, i_charge_pump_fault,
    FSR_ONES_NIBBLE, i_timeout_error, i_frame_data_error, i_header_error, i_bit_error,
    i_absolute_threshold, i_delta_threshold
  };

  // second reply contents, actual and target positions high byte first
  assign word_second = {
    FSR_MARK_BIT, i_node_address,
    i_actual_position[15:8], i_actual_position[7:0],
    i_target_position[15:8], i_target_position[7:0],
    i_secure_position[7:0],
    i_fullstep_stall_enable, FSR_MARK_BIT, i_full_duty_indicator,
    i_secure_position[10:8],
    i_absolute_stall_flag, i_delta_stall_low, i_delta_stall_high,
    i_min_sample_count,
    i_full_duty_stall_enable, i_pwm_jitter_enable
  };

  // header checks: parity must match the protected form of the carried id
  assign hdr_parity_ok = (fsr_pid(i_hdr_pid[5:0]) == i_hdr_pid);
  assign hdr_prep = i_hdr_valid && hdr_is(i_hdr_pid, FSR_ID_PREP);
  assign hdr_read = i_hdr_valid && hdr_is(i_hdr_pid, FSR_ID_READ);
  assign rx_data = (state_reg == FSR_ST_PREP) && i_rx_valid && (idx_reg != FSR_IDX_CHECKSUM);

  // expected preparing-frame byte at the current index
  always_comb begin
    case (idx_reg)
      FSR_IDX_MARKER: prep_expect = FSR_APP_MARKER;
      FSR_IDX_COMMAND: prep_expect = {FSR_MARK_BIT, FSR_CMD_FULL_STATUS};
      FSR_IDX_ADDRESS: prep_expect = {FSR_MARK_BIT, i_node_address};
      default: prep_expect = FSR_FILL;
    endcase
  end

  // transmit byte: data from the snapshot, then the inverted running sum
  assign tx_word = sending_first_reg ? snap_first_reg : snap_second_reg;
  assign tx_data = (idx_reg == FSR_IDX_CHECKSUM) ? ~sum_reg : byte_of(tx_word, idx_reg);
  assign push = (state_reg == FSR_ST_SEND) && buf_in_ready;
  assign last_push = push && (idx_reg == FSR_IDX_CHECKSUM);
  assign prep_done = (state_reg == FSR_ST_PREP) && i_rx_valid && (idx_reg == FSR_IDX_CHECKSUM);
  assign prep_good = prep_done && match_reg && (i_rx_byte == ~sum_reg);

  // frame sequencer; a new header always wins over whatever frame was in progress
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= FSR_ST_IDLE;
    end else if (i_hdr_valid) begin
      if (!hdr_parity_ok) begin
        state_reg <= FSR_ST_SKIP;
      end else if (i_hdr_pid[5:0] == FSR_ID_PREP) begin
        state_reg <= FSR_ST_PREP;
      end else if (i_hdr_pid[5:0] == FSR_ID_READ && (pend_first_reg || pend_second_reg)) begin
        state_reg <= FSR_ST_SEND;
      end else begin
        state_reg <= FSR_ST_SKIP;
      end
    end else begin
      case (state_reg)
        FSR_ST_IDLE: state_reg <= FSR_ST_IDLE;
        FSR_ST_PREP: state_reg <= prep_done ? FSR_ST_IDLE : FSR_ST_PREP;
        FSR_ST_SEND: state_reg <= last_push ? FSR_ST_IDLE : FSR_ST_SEND;
        FSR_ST_SKIP: state_reg <= FSR_ST_SKIP; // bytes of foreign frames are ignored
        default: state_reg <= FSR_ST_IDLE;
      endcase
    end
  end

  // byte index: counts data bytes in, then reply bytes out; it stops at the checksum slot
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      idx_reg <= FSR_IDX_RESET;
    end else if (i_hdr_valid) begin
      idx_reg <= FSR_IDX_RESET;
    end else if (rx_data) begin
      idx_reg <= idx_reg + 4'h1;
    end else if (push && !last_push) begin
      idx_reg <= idx_reg + 4'h1;
    end
  end

  // running checksum; one adder serves the received and the sent frame
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sum_reg <= FSR_SUM_RESET;
    end else if (i_hdr_valid) begin
      sum_reg <= FSR_SUM_RESET;
    end else if (rx_data) begin
      sum_reg <= fsr_sum_add(sum_reg, i_rx_byte);
    end else if (push && !last_push) begin
      sum_reg <= fsr_sum_add(sum_reg, tx_data);
    end
  end

  // content match: one wrong byte spoils the frame, silently, with no error pulse
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      match_reg <= 1'b0;
    end else if (i_hdr_valid) begin
      match_reg <= 1'b1;
    end else if (rx_data) begin
      match_reg <= match_reg && (i_rx_byte == prep_expect);
    end
  end

  // first reply pending; a fresh preparing frame drops any unsent answer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_first_reg <= 1'b0;
    end else if (hdr_prep) begin
      pend_first_reg <= 1'b0;
    end else if (prep_good) begin
      pend_first_reg <= 1'b1;
    end else if (last_push && sending_first_reg) begin
      pend_first_reg <= 1'b0;
    end
  end

  // second reply pending; armed only once the first is fully queued, so skipping it costs nothing
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_second_reg <= 1'b0;
    end else if (hdr_prep) begin
      pend_second_reg <= 1'b0;
    end else if (last_push) begin
      pend_second_reg <= sending_first_reg;
    end
  end

  // which reply goes out, chosen as the reading header is taken
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sending_first_reg <= 1'b0;
    end else if (hdr_read) begin
      sending_first_reg <= pend_first_reg;
    end
  end

  // snapshot taken as the first reply starts; the second reply reuses it unchanged
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      snap_first_reg <= FSR_WORD_RESET;
      snap_second_reg <= FSR_WORD_RESET;
    end else if (hdr_read && pend_first_reg) begin
      snap_first_reg <= word_first;
      snap_second_reg <= word_second;
    end
  end

  // flag clear follows the end of the first reply; the second reply still shows the
  // snapshot, so stall flags cleared early are not lost to the master
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_clear_reg <= 1'b0;
    end else begin
      flag_clear_reg <= last_push && sending_first_reg;
    end
  end

  // error pulse for a bad identifier parity or a preparing frame with a bad checksum
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      frame_error_reg <= 1'b0;
    end else begin
      frame_error_reg <= (i_hdr_valid && !hdr_parity_ok) || (prep_done && (i_rx_byte != ~sum_reg));
    end
  end

  // buffer in the transmit path so a stalled transmitter loses no byte
  fsr_buf #(
    .WIDTH(8),
    .DEPTH(BUF_DEPTH)
  ) u_tx_buf (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(state_reg == FSR_ST_SEND),
    .i_in_data(tx_data),
    .o_in_ready(buf_in_ready),
    .o_out_valid(o_tx_valid),
    .o_out_data(o_tx_byte),
    .i_out_ready(i_tx_ready)
  );

  // status outputs
  assign o_reply_pending = pend_first_reg;
  assign o_second_pending = pend_second_reg;
  assign o_busy = (state_reg == FSR_ST_PREP) || (state_reg == FSR_ST_SEND) || o_tx_valid;
  assign o_flag_clear = flag_clear_reg;
  assign o_frame_error = frame_error_reg;

endmodule : fsr_framer

`default_nettype wire

/* pkg/fsr_pkg.sv */
// Purpose: shared constants, state type and helper functions for the full-status response framer
// Assumes: a LIN data-link layer delivers header identifiers and received bytes as one-cycle strobes
// Notes: identifiers are held as 6-bit frame ids; parity bits are added by fsr_pid
`default_nettype none

package fsr_pkg;

  // frame identifiers before parity
  localparam logic [5:0] FSR_ID_PREP = 6'h3C;
  localparam logic [5:0] FSR_ID_READ = 6'h3D;

  // fixed contents of the preparing frame and the replies
  localparam logic [7:0] FSR_APP_MARKER = 8'h80;
  localparam logic [6:0] FSR_CMD_FULL_STATUS = 7'h01;
  localparam logic [7:0] FSR_FILL = 8'hFF;
  localparam logic FSR_MARK_BIT = 1'b1;
  localparam logic [3:0] FSR_ONES_NIBBLE = 4'hF;

  // byte counts: data bytes per frame, index of the checksum byte
  localparam logic [3:0] FSR_IDX_CHECKSUM = 4'h8;
  localparam logic [3:0] FSR_IDX_MARKER = 4'h0;
  localparam logic [3:0] FSR_IDX_COMMAND = 4'h1;
  localparam logic [3:0] FSR_IDX_ADDRESS = 4'h2;

  // reset values
  localparam logic [3:0] FSR_IDX_RESET = 4'h0;
  localparam logic [7:0] FSR_SUM_RESET = 8'h00;
  localparam logic [63:0] FSR_WORD_RESET = 64'h0;

  typedef enum logic [2:0] {
    FSR_ST_IDLE = 3'b000,
    FSR_ST_PREP = 3'b001,
    FSR_ST_SEND = 3'b010,
    FSR_ST_SKIP = 3'b011
  } fsr_state_e;

  // protected identifier: P1 in bit 7, P0 in bit 6
  function automatic logic [7:0] fsr_pid(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0, id};
  endfunction

  // classic checksum step: add with end-around carry; the sent byte is the inverse
  function automatic logic [7:0] fsr_sum_add(input logic [7:0] acc, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, acc} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction

endpackage : fsr_pkg

`default_nettype wire

/* rtl/fsr_buf.sv */
// Purpose: small valid/ready buffer between the framer and the bus transmitter
// Assumes: one clock; writer and reader may act in the same cycle
// Notes: default depth of two lets a stalled reader hold off the framer without loss
`default_nettype none

module fsr_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // filling side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // draining side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic push;
  logic pop;

  // full and empty come straight from the occupancy count
  assign o_in_ready = (count_reg != CNT_FULL);
  assign o_out_valid = (count_reg != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_reg[rd_ptr_reg];

  // storage has no reset; only occupied slots are ever read
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  // pointers wrap at the last slot so depth need not be a power of two
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
    end
  end

  // occupancy
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 1'b1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 1'b1;
    end
  end

endmodule : fsr_buf

`default_nettype wire

/* verification/fsr_chk.sv */
// Purpose: port-level checks for the full-status framer
// Assumes: one clock; reset asynchronous, active high
// Notes: parity is recomputed here rather than borrowed from the design
`default_nettype none
module fsr_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // link side
  input wire logic i_hdr_valid,
  input wire logic [7:0] i_hdr_pid,
  input wire logic i_rx_valid,
  input wire logic i_tx_ready,
  input wire logic [6:0] i_node_address,
  // framer outputs
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_byte,
  input wire logic o_reply_pending,
  input wire logic o_second_pending,
  input wire logic o_busy,
  input wire logic o_flag_clear,
  input wire logic o_frame_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic bad_par;
  logic rd_hdr;
  // parity from the six id bits; a wrong parity must never pass as a good header
  assign bad_par = i_hdr_pid[6] != ^{i_hdr_pid[4], i_hdr_pid[2:0]} || i_hdr_pid[7] == ^{i_hdr_pid[5:3], i_hdr_pid[1]};
  assign rd_hdr = i_hdr_valid && i_hdr_pid == 8'h7D && !o_busy;
  AST_TX_HOLD: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
    else $error("tx byte changed while stalled");
  AST_NO_ASK: assert property (rd_hdr && !o_reply_pending && !o_second_pending |-> ##2 !o_tx_valid)
    else $error("reply sent without a prepared query");
  AST_ANSWER: assert property (rd_hdr && (o_reply_pending || o_second_pending) |-> ##2 o_tx_valid)
    else $error("prepared reply not started");
  AST_FIRST_BYTE: assert property ($rose(o_tx_valid) |-> o_tx_byte == {1'b1, i_node_address})
    else $error("reply does not open with marked address");
  AST_CLEAR: assert property (o_flag_clear |=> !o_flag_clear && o_second_pending)
    else $error("flag clear not a single pulse after first reply");
  AST_PARITY: assert property (i_hdr_valid && bad_par |=> o_frame_error)
    else $error("bad header parity not flagged");
  AST_CANCEL: assert property (i_hdr_valid && i_hdr_pid == 8'h3C |=> !o_reply_pending && !o_second_pending)
    else $error("preparing header left a reply pending");
  AST_PEND_CAUSE: assert property ($rose(o_reply_pending) |-> $past(i_rx_valid) && !o_frame_error)
    else $error("reply pending without a good checksum byte");
  AST_ORDER: assert property ($rose(o_second_pending) |-> $past(o_reply_pending) || $past(o_reply_pending, 2))
    else $error("second reply armed before the first");
endmodule // fsr_chk
bind fsr_framer fsr_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_hdr_valid(i_hdr_valid), .i_hdr_pid(i_hdr_pid),
  .i_rx_valid(i_rx_valid), .i_tx_ready(i_tx_ready), .i_node_address(i_node_address), .o_tx_valid(o_tx_valid),
  .o_tx_byte(o_tx_byte), .o_reply_pending(o_reply_pending), .o_second_pending(o_second_pending),
  .o_busy(o_busy), .o_flag_clear(o_flag_clear), .o_frame_error(o_frame_error));
`default_nettype wire

/* verification/fsr_master.sv */
// Purpose: bus master model: sends headers and preparing frames, takes the slave reply
// Assumes: drives at the falling edge, one header or byte per cycle
// Notes: with stall set, ready toggles each cycle so the buffer fills and refuses
`default_nettype none
module fsr_master (
  // clock
  input wire logic i_clk,
  // toward the framer
  output logic o_hdr_valid,
  output logic [7:0] o_hdr_pid,
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte,
  output logic o_tx_ready,
  // from the framer
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stall = 1'b0;
  logic [7:0] got[$];
  // idle lines at time zero
  initial begin
    o_hdr_valid = 1'b0;
    o_hdr_pid = 8'h00;
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
    o_tx_ready = 1'b1;
  end
  // protected identifier from the six id bits
  function automatic logic [7:0] pid(input logic [5:0] id);
    return {~^{id[5:3], id[1]}, ^{id[4], id[2:0]}, id};
  endfunction
  // inverted sum with end-around carry, folded each step so it never overflows
  function automatic logic [7:0] csum(input logic [63:0] w);
    logic [7:0] a;
    logic [8:0] s;
    a = 8'h00;
    for (int i = 0; i < 8; i++) begin
      s = {1'b0, a} + {1'b0, w[8*i +: 8]};
      a = s[7:0] + {7'h00, s[8]};
    end
    return ~a;
  endfunction
  // one header; afterwards the line shows the inverse, not a stale value
  task automatic hdr(input logic [5:0] id, input logic bad);
    @(negedge i_clk);
    o_hdr_valid = 1'b1;
    o_hdr_pid = pid(id) ^ {bad, 7'h00};
    @(negedge i_clk);
    o_hdr_valid = 1'b0;
    o_hdr_pid = ~o_hdr_pid;
  endtask
  // preparing frame: header, eight data bytes, checksum, back to back
  task automatic prep(input logic [6:0] addr, input logic bad);
    logic [63:0] w;
    w = {8'h80, 1'b1, 7'h01, 1'b1, addr, 40'hFF_FFFF_FFFF};
    hdr(6'h3C, 1'b0);
    for (int i = 8; i >= 0; i--) begin
      o_rx_valid = 1'b1;
      o_rx_byte = (i == 0) ? csum(w) ^ {7'h00, bad} : w[8*i-1 -: 8];
      @(negedge i_clk);
    end
    o_rx_valid = 1'b0;
    o_rx_byte = ~o_rx_byte;
  endtask
  // receiver ready, slowed on request
  always @(negedge i_clk) o_tx_ready <= !stall || !o_tx_ready;
  // keep every byte taken from the framer
  always @(posedge i_clk) if (i_tx_valid && o_tx_ready) got.push_back(i_tx_byte);
endmodule // fsr_master
`default_nettype wire

/* verification/testbench.sv */
// Purpose: self-checking bench for the full-status response framer
// Assumes: master model drives at the falling edge; status held steady through a query
// Notes: status is one vector laid out in the order the replies report it
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [114:0] st = '0;
  wire hdr_v, rx_v, tx_v, tx_rdy, pend, pend2, clr, ferr, busy;
  wire [7:0] hdr_pid, rx_b, tx_b;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  int clears = 0;
  int errs = 0;
  always #2.5 i_clk = ~i_clk;
  fsr_master m (.i_clk(i_clk), .o_hdr_valid(hdr_v), .o_hdr_pid(hdr_pid), .o_rx_valid(rx_v), .o_rx_byte(rx_b),
    .o_tx_ready(tx_rdy), .i_tx_valid(tx_v), .i_tx_byte(tx_b));
  fsr_framer #(.BUF_DEPTH(2)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_hdr_valid(hdr_v), .i_hdr_pid(hdr_pid),
    .i_rx_valid(rx_v), .i_rx_byte(rx_b), .o_tx_valid(tx_v), .o_tx_byte(tx_b), .i_tx_ready(tx_rdy),
    .i_node_address(st[6:0]), .i_run_current(st[15:12]), .i_hold_current(st[11:8]), .i_top_speed(st[23:20]),
    .i_start_speed(st[19:16]), .i_accel_profile_shape(st[31]), .i_microstep_resolution(st[30:29]),
    .i_direction(st[28]), .i_acceleration(st[27:24]), .i_logic_supply_reset_flag(st[39]),
    .i_lost_steps_flag(st[38]), .i_coil_fault(st[37]), .i_undervoltage_flag(st[36]), .i_thermal_shutdown(st[35]),
    .i_thermal_warning(st[34]), .i_temperature_info(st[33:32]), .i_motion_state(st[47:45]),
    .i_external_switch(st[44]), .i_coil_x_overcurrent(st[43]), .i_coil_y_overcurrent(st[42]),
    .i_stall_flag(st[41]), .i_charge_pump_fault(st[40]), .i_timeout_error(st[51]), .i_frame_data_error(st[50]),
    .i_header_error(st[49]), .i_bit_error(st[48]), .i_absolute_threshold(st[59:56]),
    .i_delta_threshold(st[55:52]), .i_actual_position(st[75:60]), .i_target_position(st[91:76]),
    .i_secure_position(st[102:92]), .i_fullstep_stall_enable(st[105:103]), .i_full_duty_indicator(st[106]),
    .i_absolute_stall_flag(st[114]), .i_delta_stall_low(st[113]), .i_delta_stall_high(st[112]),
    .i_min_sample_count(st[111:109]), .i_full_duty_stall_enable(st[108]), .i_pwm_jitter_enable(st[107]),
    .o_reply_pending(pend), .o_second_pending(pend2), .o_busy(busy), .o_flag_clear(clr), .o_frame_error(ferr));
  // pulse counters and a ceiling on run length
  always @(posedge i_clk) begin
    cyc++;
    if (clr === 1'b1) clears++;
    if (ferr === 1'b1) errs++;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // expected replies, first data byte in the top bits
  function automatic logic [63:0] w1();
    return {1'b1, st[6:0], st[15:8], st[23:16], st[31:24], st[39:32], st[47:40], 4'hF, st[51:48], st[59:52]};
  endfunction
  function automatic logic [63:0] w2();
    return {1'b1, st[6:0], st[75:60], st[91:76], st[99:92], st[105:103], 1'b1, st[106], st[102:100], st[114:107]};
  endfunction
  // one reading frame; a short wait after the ninth byte catches any extra byte
  task automatic rd(input logic [63:0] w);
    m.got.delete();
    m.hdr(6'h3D, 1'b0);
    chk("busy sending", 8'h01, {7'h00, busy});
    for (int i = 0; i < 60 && m.got.size() < 9; i++) @(posedge i_clk);
    repeat (4) @(negedge i_clk);
    chk("byte count", 8'h09, 8'(m.got.size()));
    chk("busy after reply", 8'h00, {7'h00, busy});
    for (int i = 0; i < 9 && m.got.size() == 9; i++) begin
      chk("reply byte", i < 8 ? w[63-8*i -: 8] : m.csum(w), m.got[i]);
    end
  endtask
  // full query with both replies; the stalled run keeps the buffer full
  task automatic t_query(input logic [114:0] v, input logic s);
    int c;
    @(negedge i_clk);
    st = v;
    m.stall = s;
    c = clears;
    m.prep(st[6:0], 1'b0);
    @(negedge i_clk);
    chk("pending", 8'h01, {7'h00, pend});
    rd(w1());
    chk("flag clears", 8'h01, 8'(clears - c));
    rd(w2());
    chk("second left", 8'h00, {7'h00, pend2});
    $display("query test done");
  endtask
  // refused requests: wrong address, bad checksum, bad parity, unasked read
  task automatic t_refuse();
    int e;
    e = errs;
    m.prep(~st[6:0], 1'b0);
    repeat (2) @(negedge i_clk);
    chk("pending", 8'h00, {7'h00, pend});
    m.prep(st[6:0], 1'b1);
    m.hdr(6'h3C, 1'b1);
    repeat (2) @(negedge i_clk);
    chk("frame errors", 8'h02, 8'(errs - e));
    chk("pending", 8'h00, {7'h00, pend});
    m.got.delete();
    m.hdr(6'h3D, 1'b0);
    repeat (12) @(negedge i_clk);
    chk("unasked bytes", 8'h00, 8'(m.got.size()));
    $display("refuse test done");
  endtask
  // a new preparing frame drops the unfetched second reply
  task automatic t_skip();
    m.stall = 1'b0;
    m.prep(st[6:0], 1'b0);
    rd(w1());
    m.prep(st[6:0], 1'b0);
    @(negedge i_clk);
    chk("second dropped", 8'h00, {7'h00, pend2});
    rd(w1());
    $display("skip test done");
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // reset for ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    t_query(115'({4{32'hA5C3_96E1}}), 1'b0);
    t_query(~115'({4{32'hA5C3_96E1}}), 1'b1);
    t_refuse();
    t_skip();
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
